// *** hw/smw_params.svh ***
/*
 Constants for the switch mode watchdog: command layout, reset values, timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SMW_PARAMS_SVH
`define SMW_PARAMS_SVH

// Timing base
`define SMW_CLK_MHZ       100
`define SMW_WD_BASE_MS    10

// Command word layout
`define SMW_CMD_REFRESH   7
`define SMW_CMD_SEL_HI    6
`define SMW_CMD_SEL_LO    5
`define SMW_SEL_OUT       2'h0
`define SMW_SEL_OCL       2'h1
`define SMW_SEL_OCT       2'h2
`define SMW_SEL_WD        2'h3

// Reply word layout
`define SMW_RPL_WATCHDOG_EXPIRED_FLAG      2

// Reset values
`define SMW_CFG_RST       11'h000
`define SMW_OCL_RST       3'h0
`define SMW_OCH_RST       1'h0
`define SMW_OCT_RST       2'h0
`define SMW_PIN_RST       11'h002

`endif

// *** hw/smw_pkg.sv ***
/*
 Types shared by the switch mode watchdog: modes, fail-safe resistor codes,
 configuration and synchronised pin bundles. Assumes no other package.
*/
package smw_pkg;

	typedef enum logic [1:0] {
		SMW_SLEEP    = 2'h0,
		SMW_NORMAL   = 2'h1,
		SMW_FAULT    = 2'h3,
		SMW_FAILSAFE = 2'h2
	} smw_mode_e;

	typedef enum logic [1:0] {
		SMW_RFS_GND  = 2'h0,
		SMW_RFS_6K   = 2'h1,
		SMW_RFS_17K  = 2'h2,
		SMW_RFS_OPEN = 2'h3
	} smw_rfs_e;

	typedef struct packed {
		logic [1:0] out_on;
		logic [2:0] overcurrent_low_level_sel;
		logic       overcurrent_high_level_sel;
		logic [1:0] overcurrent_blank_time_sel;
		logic [1:0] watchdog_period_select;
		logic       wd_dis;
	} smw_cfg_s;

	typedef struct packed {
		logic       wake;
		logic       reset_n;
		smw_rfs_e   failsafe_select_input;
		logic [1:0] direct;
		logic [1:0] fault;
		logic       vdd_ok;
		logic       cs_n;
		logic       cmd_tgl;
	} smw_pin_s;

endpackage

// *** hw/smw_top.sv ***
/*
 Mode controller and watchdog of a dual high-side switch, with its serial slave.
 Assumes a 100 MHz reference clock, a host that makes the serial clock and
 keeps it idle outside frames, and analog fault detection on fault_detect_in.
*/
`timescale 1ns/100ps
`include "smw_params.svh"

module smw_top #(
	parameter int unsigned WD_BASE_CYCLES = `SMW_WD_BASE_MS * 1000 * `SMW_CLK_MHZ
) (
	input  wire logic             ref_clk_in,
	input  wire logic             arst_n_in,
	input  wire logic             link_sclk_in,
	input  wire logic             link_cs_n_in,
	input  wire logic             link_si_in,
	input  wire logic             wake_in,
	input  wire logic             reset_n_pin_in,
	input  wire smw_pkg::smw_rfs_e failsafe_select_input_in,
	input  wire logic [1:0]       direct_drive_input_in,
	input  wire logic [1:0]       fault_detect_in,
	input  wire logic             logic_supply_ok_in,
	output logic                  link_so_out,
	output logic                  link_so_oe_out,
	output logic                  load_output_0_out,
	output logic                  load_output_1_out,
	output logic                  fault_flag_n_out,
	output logic                  fault_flag_n_oe_out,
	output smw_pkg::smw_mode_e    mode_out,
	output logic                  watchdog_expired_flag_out,
	output smw_pkg::smw_cfg_s     cfg_out
);
	import smw_pkg::*;

	// Reset release
	logic [1:0] rst_sync_r;
	wire        rst_n = rst_sync_r[1];

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	// Link domain: frame state cleared by chip select high
	logic [2:0] bit_cnt_r;
	logic [6:0] rx_sh_r;
	logic [6:0] tx_sh_r;
	logic       so_r;
	logic [7:0] cmd_word_r;
	logic       cmd_tgl_r;
	logic [7:0] reply_r;

	wire        first_bit = (bit_cnt_r == 3'h0);
	wire        last_bit  = (bit_cnt_r == 3'h7);
	wire        so_nxt    = first_bit ? reply_r[7] : tx_sh_r[6];
	wire  [6:0] tx_nxt    = first_bit ? reply_r[6:0] : {tx_sh_r[5:0], 1'b0};

	always_ff @(posedge link_sclk_in or posedge link_cs_n_in) begin
		if (link_cs_n_in) begin
			bit_cnt_r <= 3'h0;
			rx_sh_r   <= 7'h00;
			tx_sh_r   <= 7'h00;
			so_r      <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			rx_sh_r   <= {rx_sh_r[5:0], link_si_in};
			so_r      <= so_nxt;
			tx_sh_r   <= tx_nxt;
		end
	end

	// Completed word held until the next one; toggle marks it
	always_ff @(posedge link_sclk_in or negedge rst_n) begin
		if (!rst_n) begin
			cmd_word_r <= 8'h00;
			cmd_tgl_r  <= 1'b0;
		end else if (last_bit) begin
			cmd_word_r <= {rx_sh_r, link_si_in};
			cmd_tgl_r  <= ~cmd_tgl_r;
		end
	end

	assign link_so_out = so_r;

	// Pin and toggle synchronisers
	smw_pin_s pin_raw;
	smw_pin_s pin_m_r;
	smw_pin_s pin_r;
	smw_pin_s pin_d_r;

	assign pin_raw = {wake_in, reset_n_pin_in, failsafe_select_input_in, direct_drive_input_in,
		fault_detect_in, logic_supply_ok_in, link_cs_n_in, cmd_tgl_r};

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_m_r <= `SMW_PIN_RST;
			pin_r   <= `SMW_PIN_RST;
			pin_d_r <= `SMW_PIN_RST;
		end else begin
			pin_m_r <= pin_raw;
			pin_r   <= pin_m_r;
			pin_d_r <= pin_r;
		end
	end

	// System state
	smw_mode_e  mode_r;
	smw_mode_e  mode_nxt;
	smw_cfg_s   cfg_r;
	smw_cfg_s   cfg_nxt;
	logic       wd_armed_r;
	logic [31:0] wd_cnt_r;
	logic       last_refresh_r;
	logic [1:0] fault_lat_r;
	logic [1:0] load_r;
	logic       flag_pull_r;
	logic       so_oe_r;
	logic       watchdog_expired_flag_r;

	// Word is stable: the toggle lands well before eight more clocks
	wire        cmd_done   = pin_r.cmd_tgl ^ pin_d_r.cmd_tgl;
	wire        refresh    = cmd_done && (cmd_word_r[`SMW_CMD_REFRESH] != last_refresh_r);
	wire  [1:0] cmd_sel    = cmd_word_r[`SMW_CMD_SEL_HI:`SMW_CMD_SEL_LO];
	wire        fsi_gnd    = (pin_r.failsafe_select_input == SMW_RFS_GND);
	wire        asleep     = !pin_r.wake && !pin_r.reset_n;
	wire        arm_edge   = (pin_r.wake && !pin_d_r.wake) || (pin_r.reset_n && !pin_d_r.reset_n);
	wire        fault_any  = |pin_r.fault;
	wire        active     = (mode_r == SMW_NORMAL) || (mode_r == SMW_FAULT);
	wire        wd_run     = wd_armed_r && !fsi_gnd && !cfg_r.wd_dis && active;
	wire [31:0] wd_limit   = 32'(WD_BASE_CYCLES) << cfg_r.watchdog_period_select;
	wire        wd_expire  = wd_run && !refresh && (wd_cnt_r >= wd_limit - 32'h1);
	wire        fs_exit    = asleep || fsi_gnd;
	smw_mode_e  run_mode;
	assign      run_mode   = fault_any ? SMW_FAULT : SMW_NORMAL;
	wire        fs_enter   = (mode_nxt == SMW_FAILSAFE) && (mode_r != SMW_FAILSAFE);
	wire        cfg_wr     = cmd_done && active;
	wire  [1:0] fs_pat     = (pin_r.failsafe_select_input == SMW_RFS_OPEN) ? 2'h3 :
	                         (pin_r.failsafe_select_input == SMW_RFS_17K)  ? 2'h1 : 2'h0;
	wire  [1:0] cmd_on     = cfg_r.out_on | pin_r.direct;
	wire  [1:0] load_nxt   = (mode_r == SMW_FAILSAFE) ? fs_pat :
	                         (mode_r == SMW_FAULT)    ? (cmd_on & ~pin_r.fault) :
	                         (mode_r == SMW_NORMAL)   ? cmd_on : 2'h0;
	wire  [1:0] lat_nxt    = (cmd_done ? 2'h0 : fault_lat_r) | pin_r.fault;
	wire  [7:0] reply_nxt  = {fault_lat_r, fault_any, fsi_gnd, wd_armed_r,
	                          mode_r == SMW_FAILSAFE, mode_r};
	wire        arm_nxt    = fs_exit ? 1'b0 : (arm_edge ? 1'b1 : wd_armed_r);
	wire [31:0] cnt_nxt    = (!wd_run || refresh) ? 32'h0 : wd_cnt_r + 32'h1;

	// Mode sequencing
	always_comb begin
		mode_nxt = mode_r;
		if (asleep) begin
			mode_nxt = SMW_SLEEP;
		end else begin
			case (mode_r)
				SMW_FAILSAFE: begin
					mode_nxt = fsi_gnd ? run_mode : SMW_FAILSAFE;
				end
				default: begin
					mode_nxt = wd_expire ? SMW_FAILSAFE : run_mode;
				end
			endcase
		end
	end

	// Configuration
	always_comb begin
		cfg_nxt = cfg_r;
		if (asleep || !pin_r.vdd_ok) begin
			cfg_nxt = `SMW_CFG_RST;
		end else if (fs_enter) begin
			cfg_nxt.overcurrent_low_level_sel  = `SMW_OCL_RST;
			cfg_nxt.overcurrent_high_level_sel = `SMW_OCH_RST;
			cfg_nxt.overcurrent_blank_time_sel = `SMW_OCT_RST;
		end else if (cfg_wr) begin
			case (cmd_sel)
				`SMW_SEL_OUT: begin
					cfg_nxt.out_on = cmd_word_r[1:0];
				end
				`SMW_SEL_OCL: begin
					cfg_nxt.overcurrent_low_level_sel  = cmd_word_r[2:0];
					cfg_nxt.overcurrent_high_level_sel = cmd_word_r[3];
				end
				`SMW_SEL_OCT: begin
					cfg_nxt.overcurrent_blank_time_sel = cmd_word_r[1:0];
				end
				default: begin
					cfg_nxt.watchdog_period_select = cmd_word_r[1:0];
					cfg_nxt.wd_dis                 = cmd_word_r[2];
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= SMW_SLEEP;
			cfg_r  <= `SMW_CFG_RST;
		end else begin
			mode_r <= mode_nxt;
			cfg_r  <= cfg_nxt;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wd_armed_r     <= 1'b0;
			wd_cnt_r       <= 32'h0;
			last_refresh_r <= 1'b0;
		end else begin
			wd_armed_r <= arm_nxt;
			wd_cnt_r   <= cnt_nxt;
			if (cmd_done) begin
				last_refresh_r <= cmd_word_r[`SMW_CMD_REFRESH];
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			fault_lat_r <= 2'h0;
			load_r      <= 2'h0;
			flag_pull_r <= 1'b0;
			so_oe_r     <= 1'b0;
			watchdog_expired_flag_r      <= 1'b0;
		end else begin
			fault_lat_r <= lat_nxt;
			load_r      <= load_nxt;
			flag_pull_r <= fault_any;
			so_oe_r     <= !pin_r.cs_n;
			watchdog_expired_flag_r      <= (mode_r == SMW_FAILSAFE);
		end
	end

	// Reply frozen while a frame is in progress
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			reply_r <= 8'h00;
		end else if (pin_r.cs_n) begin
			reply_r <= reply_nxt;
		end
	end

	assign link_so_oe_out            = so_oe_r;
	assign load_output_0_out         = load_r[0];
	assign load_output_1_out         = load_r[1];
	assign fault_flag_n_out          = ~flag_pull_r;
	assign fault_flag_n_oe_out       = flag_pull_r;
	assign mode_out                  = mode_r;
	assign watchdog_expired_flag_out = watchdog_expired_flag_r;
	assign cfg_out                   = cfg_r;

	// Checks
	a_flag_follows_fault: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		fault_any |=> flag_pull_r && !fault_flag_n_out) else $error("fault flag not pulled");
	a_failsafe_load_pattern: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		(mode_r == SMW_FAILSAFE) |=> (load_r == $past(fs_pat))) else $error("fail-safe pattern wrong");
	a_gnd_disarms_dog: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		fsi_gnd |=> !wd_armed_r && (mode_r != SMW_FAILSAFE)) else $error("grounded select left watchdog on");
	a_oe_off_unselected: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		pin_r.cs_n [*2] |-> !link_so_oe_out) else $error("serial output driven while unselected");
	a_sleep_loads_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		(mode_r == SMW_SLEEP) |=> (load_r == 2'h0)) else $error("load on in sleep");
	a_sleep_cfg_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		(mode_r == SMW_SLEEP) |-> (cfg_r == `SMW_CFG_RST)) else $error("configuration kept in sleep");
	a_fault_output_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		(mode_r == SMW_FAULT) && pin_r.fault[0] |=> !load_r[0]) else $error("faulted output left on");
	a_edge_arms_dog: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		arm_edge && !fs_exit |=> wd_armed_r) else $error("watchdog not armed");
	a_expiry_latches: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		wd_expire && !asleep |=> (mode_r == SMW_FAILSAFE) ##1 watchdog_expired_flag_out)
		else $error("expiry did not latch fail-safe");
	a_oc_fields_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		fs_enter && pin_r.vdd_ok |=> cfg_r.overcurrent_low_level_sel == `SMW_OCL_RST &&
		cfg_r.overcurrent_blank_time_sel == `SMW_OCT_RST && cfg_r.out_on == $past(cfg_r.out_on))
		else $error("overcurrent fields not restored");
	a_exit_on_sleep: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		(mode_r == SMW_FAILSAFE) && asleep |=> (mode_r == SMW_SLEEP)) else $error("fail-safe not left");
	a_latch_cleared: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		cmd_done && !fault_any |=> (fault_lat_r == 2'h0)) else $error("fault latch not cleared");
	a_refresh_restarts: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
		refresh |=> (wd_cnt_r == 32'h0) ##1 (wd_cnt_r <= 32'h1)) else $error("refresh did not restart count");
	a_word_msb_first: assert property (@(posedge link_sclk_in) disable iff (!rst_n)
		last_bit |=> cmd_word_r == {$past(rx_sh_r), $past(link_si_in)}) else $error("command word misassembled");

	c_failsafe_entry: cover property (@(posedge ref_clk_in) disable iff (!rst_n) fs_enter);
	c_refresh_seen: cover property (@(posedge ref_clk_in) disable iff (!rst_n) refresh ##[1:200] refresh);
	c_fault_mode: cover property (@(posedge ref_clk_in) disable iff (!rst_n) mode_r == SMW_FAULT);
	c_frame_done: cover property (@(posedge link_sclk_in) disable iff (link_cs_n_in) last_bit);

endmodule

// *** test/smw_host_model.sv ***
/*
 Serial master standing in for the host controller of the switch mode watchdog.
 Assumes one frame at a time, called by the bench; link clock period 32 ns.
*/
`timescale 1ns/100ps
module smw_host_model (
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      si_out,
	input  wire logic so_in,
	input  wire logic so_oe_in
);
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out   = 1'b0;
	end

	// Clock idles low outside frames, data line is driven low after each frame
	task automatic xfer(input logic [7:0] cmd, output logic [7:0] rpl, output logic oe_seen);
		#3.3;
		cs_n_out = 1'b0;
		#200;
		oe_seen = so_oe_in;
		for (int i = 7; i >= 0; i--) begin
			si_out = cmd[i];
			#16 sclk_out = 1'b1;
			#16 sclk_out = 1'b0;
			rpl[i] = so_in;
		end
		#50 cs_n_out = 1'b1;
		si_out = 1'b0;
		#300;
	endtask
endmodule

// *** test/switch_mode_watchdog_spi_tb_top.sv ***
/*
 Self-checking bench for the switch mode watchdog, with a model of modes, config and loads.
 Assumes smw_host_model as serial master and a short watchdog base period.
*/
`timescale 1ns/100ps
`include "smw_params.svh"
module switch_mode_watchdog_spi_tb_top;
	import smw_pkg::*;
	logic       ref_clk, arst_n, sclk, cs_n, si, wake, rst_pin, sup_ok;
	logic       so, so_oe, ld0, ld1, ffn, ffn_oe, wdx, oe_seen;
	logic [1:0] drv, flt;
	logic [7:0] rpl;
	smw_rfs_e   failsafe_select_input;
	smw_mode_e  mode, m_mode;
	smw_cfg_s   cfg;
	smw_rfs_e   fs_list[$];
	int         err_total, samples_checked, seed, n, last_wd;
	int         m_out, m_ocl, m_och, m_oct, m_wdr, m_dis;

	smw_top #(.WD_BASE_CYCLES(200)) i_dut (
		.ref_clk_in(ref_clk), .arst_n_in(arst_n), .link_sclk_in(sclk), .link_cs_n_in(cs_n),
		.link_si_in(si), .wake_in(wake), .reset_n_pin_in(rst_pin), .failsafe_select_input_in(failsafe_select_input),
		.direct_drive_input_in(drv), .fault_detect_in(flt), .logic_supply_ok_in(sup_ok),
		.link_so_out(so), .link_so_oe_out(so_oe), .load_output_0_out(ld0), .load_output_1_out(ld1),
		.fault_flag_n_out(ffn), .fault_flag_n_oe_out(ffn_oe), .mode_out(mode),
		.watchdog_expired_flag_out(wdx), .cfg_out(cfg)
	);
	smw_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	function automatic logic [10:0] m_cfg();
		return {m_out[1:0], m_ocl[2:0], m_och[0], m_oct[1:0], m_wdr[1:0], m_dis[0]};
	endfunction

	function automatic logic [1:0] exp_ld();
		if (m_mode == SMW_SLEEP)
			return 2'h0;
		if (m_mode == SMW_FAILSAFE)
			return (failsafe_select_input == SMW_RFS_OPEN) ? 2'h3 : (failsafe_select_input == SMW_RFS_17K) ? 2'h1 : 2'h0;
		return m_out[1:0] & ~flt;
	endfunction

	task automatic m_clear();
		{m_out, m_ocl, m_och, m_oct, m_wdr, m_dis} = '0;
	endtask

	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wait_mode(input smw_mode_e exp);
		for (n = 0; n < 30 && mode !== exp; n++)
			@(negedge ref_clk);
		chk("mode", 11'(exp), 11'(mode));
		if (mode !== exp)
			conclude();
	endtask

	// Each command flips the refresh bit and is applied to the model only when accepted
	task automatic send(input int sel, input int d);
		last_wd = 1 - last_wd;
		i_host.xfer({last_wd[0], sel[1:0], d[4:0]}, rpl, oe_seen);
		if (m_mode == SMW_NORMAL || m_mode == SMW_FAULT) begin
			case (sel)
				0: m_out = d & 3;
				1: begin
					m_ocl = d & 7;
					m_och = (d >> 3) & 1;
				end
				2: m_oct = d & 3;
				default: begin
					m_wdr = d & 3;
					m_dis = (d >> 2) & 1;
				end
			endcase
		end
		@(negedge ref_clk);
		chk("cfg", m_cfg(), cfg);
		chk("loads", 11'(exp_ld()), 11'({ld1, ld0}));
		chk("reply mode", 11'(m_mode), 11'(rpl[1:0]));
		chk("expired", 11'({2{m_mode == SMW_FAILSAFE}}), 11'({rpl[`SMW_RPL_WATCHDOG_EXPIRED_FLAG], wdx}));
		chk("fault flag", 11'({flt != 2'h0, 1'b0}), 11'({ffn_oe, ffn & ffn_oe}));
		chk("so enable", 11'h2, 11'({oe_seen, so_oe}));
	endtask

	initial begin
		{arst_n, wake, rst_pin, drv, flt, last_wd, err_total, samples_checked} = '0;
		sup_ok = 1'b1;
		failsafe_select_input = SMW_RFS_OPEN;
		seed = 5;
		m_mode = SMW_SLEEP;
		m_clear();
		fs_list = '{SMW_RFS_6K, SMW_RFS_17K, SMW_RFS_OPEN};
		repeat (10) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk("mode", 11'(SMW_SLEEP), 11'(mode));
		chk("idle pins", 11'h0, 11'({ld1, ld0, so_oe, cfg}));
		$display("test reset done");
		rst_pin = 1'b1;
		m_mode = SMW_NORMAL;
		wait_mode(SMW_NORMAL);
		for (int i = 0; i < 8; i++)
			send(i % 4, (i % 4 == 3) ? 0 : $random(seed));
		chk("mode", 11'(SMW_NORMAL), 11'(mode));
		$display("test commands done");
		send(0, 3);
		flt = 2'h1;
		m_mode = SMW_FAULT;
		wait_mode(SMW_FAULT);
		send(0, 3);
		chk("reply faults", 11'h3, 11'(rpl[7:5]));
		flt = 2'h0;
		m_mode = SMW_NORMAL;
		wait_mode(SMW_NORMAL);
		send(0, 3);
		chk("latched faults", 11'h2, 11'(rpl[7:5]));
		send(0, 3);
		chk("latched faults", 11'h0, 11'(rpl[7:5]));
		$display("test fault done");
		foreach (fs_list[k]) begin
			failsafe_select_input = fs_list[k];
			send(0, $random(seed));
			n = 0;
			while (mode !== SMW_FAILSAFE && n < 8) begin
				i_host.xfer({last_wd[0], 5'h0, m_out[1:0]}, rpl, oe_seen);
				n++;
			end
			chk("stall frames", 11'h1, 11'(n > 1));
			m_mode = SMW_FAILSAFE;
			wait_mode(SMW_FAILSAFE);
			{m_ocl, m_och, m_oct} = '0;
			drv = 2'($random(seed));
			send(1, $random(seed));
			drv = 2'h0;
			if (k == 2) begin
				failsafe_select_input = SMW_RFS_GND;
				m_mode = SMW_NORMAL;
				wait_mode(SMW_NORMAL);
			end else begin
				rst_pin = 1'b0;
				m_mode = SMW_SLEEP;
				m_clear();
				wait_mode(SMW_SLEEP);
				send(0, 3);
				rst_pin = 1'b1;
				m_mode = SMW_NORMAL;
				wait_mode(SMW_NORMAL);
			end
			$display("test fail-safe pattern %0d done", k);
		end
		repeat (400) @(negedge ref_clk);
		chk("grounded select", 11'(SMW_NORMAL), 11'({wdx, mode}));
		send(1, 15);
		sup_ok = 1'b0;
		m_clear();
		for (n = 0; n < 30 && cfg !== 11'h0; n++)
			@(negedge ref_clk);
		chk("cfg supply loss", 11'h0, cfg);
		sup_ok = 1'b1;
		$display("test select and supply done");
		conclude();
	end
endmodule
